// >>> src/adc_burst_gain_result_control.sv
// Converter sequencing, gain access and result formatting
`timescale 1ns/1ps
module adc_burst_gain_result_control
    import adc_burst_pkg::*;
(
    input  wire logic       sys_clk,
    input  wire logic       rst_b,
    input  wire logic [7:0] sfr_addr,
    input  wire logic [7:0] sfr_wdata,
    input  wire logic       sfr_wr,
    output logic      [7:0] sfr_rdata,
    input  wire logic       burst_mode_on,
    input  wire logic       converter_power_keep,
    input  wire logic [4:0] powerup_delay_field,
    input  wire logic [1:0] repeat_count_field,
    input  wire logic       left_justify_select,
    input  wire logic       gain_access_enable,
    input  wire logic       convert_start,
    input  wire logic       done_clear,
    output logic            conversion_busy_bit,
    output logic            conversion_done_flag,
    output core_ctrl_t      core_ctrl,
    input  wire logic       core_done,
    input  wire logic [11:0] core_data,
    output gain_t           gain_out
);

    // ==========================================================
    // Burst clock enable
    // ==========================================================
    typedef enum logic [2:0] {S_IDLE, S_POWERUP, S_TRACK, S_CONVERT, S_WAIT} state_t;

    state_t      state_q;
    logic [$clog2(BURST_DIV+1)-1:0] div_q;
    logic        tick;
    logic [8:0]  wait_q;
    logic [4:0]  count_q;
    logic [4:0]  total;
    logic [15:0] acc_q;
    logic [15:0] result_q;
    logic        powered_q;
    logic        last_conv;
    logic        seq_done;
    logic [7:0]  gain_ptr_q;
    logic        gain_wr;
    logic [7:0]  coarse_q;
    logic [3:0]  fine_q;
    logic        offset_add_q;
    logic [7:0]  high_mask;
    logic [7:0]  fmt_high;
    logic [7:0]  fmt_low;

    // Two system cycles per burst tick
    assign tick = (div_q == '0);

    always_ff @(posedge sys_clk or negedge rst_b)
    begin
        if (!rst_b)
            div_q <= '0;
        else if (div_q == ($clog2(BURST_DIV+1))'(BURST_DIV - 1))
            div_q <= '0;
        else
            div_q <= div_q + 1'b1;
    end

    // ==========================================================
    // Repeat count
    // ==========================================================
    always_comb
    begin
        unique case (repeat_count_field)
            RPT_1:   total = 5'h01;
            RPT_4:   total = 5'h04;
            RPT_8:   total = 5'h08;
            RPT_16:  total = 5'h10;
        endcase
    end

    // Also ends a sequence whose repeat code shrank midway
    assign last_conv = (count_q + 5'h01 >= total);
    assign seq_done  = (state_q == S_WAIT) && core_done && last_conv;

    // ==========================================================
    // Sequencer
    // ==========================================================
    always_ff @(posedge sys_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            state_q <= S_IDLE;
            wait_q  <= '0;
        end
        else
        begin
            unique case (state_q)
                S_IDLE:
                begin
                    // Outside burst a powered-off converter would never answer
                    if (convert_start && (burst_mode_on || powered_q))
                    begin
                        if (burst_mode_on && !powered_q)
                        begin
                            state_q <= S_POWERUP;
                            wait_q  <= 9'({powerup_delay_field, 3'h0}) + 9'(POWERUP_UNIT);
                        end
                        else
                        begin
                            state_q <= S_TRACK;
                            wait_q  <= 9'(TRACK_TICKS);
                        end
                    end
                end
                S_POWERUP, S_TRACK:
                begin
                    if (tick)
                    begin
                        if (wait_q == 9'h001)
                        begin
                            if (state_q == S_POWERUP)
                            begin
                                state_q <= S_TRACK;
                                wait_q  <= 9'(TRACK_TICKS);
                            end
                            else
                                state_q <= S_CONVERT;
                        end
                        else
                            wait_q <= wait_q - 9'h001;
                    end
                end
                S_CONVERT:
                    state_q <= S_WAIT;
                S_WAIT:
                begin
                    if (core_done)
                    begin
                        if (burst_mode_on && !last_conv)
                        begin
                            state_q <= S_TRACK;
                            wait_q  <= 9'(TRACK_TICKS);
                        end
                        else
                            state_q <= S_IDLE;
                    end
                end
                // Illegal codes fall back to idle
                default:
                    state_q <= S_IDLE;
            endcase
        end
    end

    // ==========================================================
    // Converter power
    // ==========================================================
    always_ff @(posedge sys_clk or negedge rst_b)
    begin
        if (!rst_b)
            powered_q <= 1'b0;
        else if (!burst_mode_on)
            powered_q <= converter_power_keep;
        else if (state_q == S_POWERUP)
            powered_q <= 1'b1;
        else if (state_q == S_IDLE && !convert_start)
            powered_q <= converter_power_keep;
    end

    always_comb
    begin
        core_ctrl.power_on = powered_q;
        core_ctrl.track    = (state_q == S_TRACK);
        core_ctrl.convert  = (state_q == S_CONVERT);
    end

    // ==========================================================
    // Sequence counter
    // ==========================================================
    // Kept across idle so that normal mode sums one start at a time
    always_ff @(posedge sys_clk or negedge rst_b)
    begin
        if (!rst_b)
            count_q <= '0;
        else if (state_q == S_WAIT && core_done)
            count_q <= last_conv ? 5'h00 : count_q + 5'h01;
    end

    // ==========================================================
    // Accumulation and result
    // ==========================================================
    always_ff @(posedge sys_clk or negedge rst_b)
    begin
        if (!rst_b)
            acc_q <= '0;
        else if (state_q == S_IDLE && convert_start && count_q == '0)
            acc_q <= '0;
        else if (state_q == S_WAIT && core_done)
            acc_q <= acc_q + 16'(core_data);
    end

    // Final sample joins the sum as it arrives
    always_ff @(posedge sys_clk or negedge rst_b)
    begin
        if (!rst_b)
            result_q <= '0;
        else if (seq_done)
            result_q <= acc_q + 16'(core_data);
    end

    always_ff @(posedge sys_clk or negedge rst_b)
    begin
        if (!rst_b)
            conversion_done_flag <= 1'b0;
        // Set wins over a clear in the same cycle
        else if (seq_done)
            conversion_done_flag <= 1'b1;
        else if (done_clear)
            conversion_done_flag <= 1'b0;
    end

    assign conversion_busy_bit = (state_q != S_IDLE);

    // ==========================================================
    // Output formatting
    // ==========================================================
    always_comb
    begin
        unique case (repeat_count_field)
            RPT_1:   high_mask = 8'h0F;
            RPT_4:   high_mask = 8'h1F;
            RPT_8:   high_mask = 8'h3F;
            RPT_16:  high_mask = 8'hFF;
        endcase
        if (left_justify_select)
        begin
            fmt_high = result_q[11:4];
            fmt_low  = {result_q[3:0], 4'h0};
        end
        else
        begin
            fmt_high = result_q[15:8] & high_mask;
            fmt_low  = result_q[7:0];
        end
    end

    // ==========================================================
    // Indirect gain access
    // ==========================================================
    // Pointer moves only while gain access is on
    always_ff @(posedge sys_clk or negedge rst_b)
    begin
        if (!rst_b)
            gain_ptr_q <= RESET_RESULT;
        else if (sfr_wr && gain_access_enable && sfr_addr == ADDR_RESULT_HIGH)
            gain_ptr_q <= sfr_wdata;
    end

    assign gain_wr = sfr_wr && gain_access_enable && (sfr_addr == ADDR_RESULT_LOW);

    always_ff @(posedge sys_clk or negedge rst_b)
    begin
        if (!rst_b)
            coarse_q <= GAIN_COARSE_RST;
        else if (gain_wr && gain_ptr_q == GAIN_ADDR_COARSE)
            coarse_q <= sfr_wdata;
    end

    always_ff @(posedge sys_clk or negedge rst_b)
    begin
        if (!rst_b)
            fine_q <= GAIN_FINE_RST;
        else if (gain_wr && gain_ptr_q == GAIN_ADDR_FINE)
            fine_q <= sfr_wdata[GAIN_FINE_LSB +: 4];
    end

    always_ff @(posedge sys_clk or negedge rst_b)
    begin
        if (!rst_b)
            offset_add_q <= 1'b0;
        else if (gain_wr && gain_ptr_q == GAIN_ADDR_EXTRA)
            offset_add_q <= sfr_wdata[GAIN_ADD_BIT];
    end

    assign gain_out = {coarse_q, fine_q, offset_add_q};

    // ==========================================================
    // Register read
    // ==========================================================
    always_comb
    begin
        sfr_rdata = 8'h00;
        if (sfr_addr == ADDR_RESULT_HIGH)
            sfr_rdata = gain_access_enable ? gain_ptr_q : fmt_high;
        else if (sfr_addr == ADDR_RESULT_LOW)
            sfr_rdata = gain_access_enable ? 8'h00 : fmt_low;
    end

endmodule : adc_burst_gain_result_control

// >>> src/adc_burst_pkg.sv
// Constants, types and register map of the burst/gain/result converter control
package adc_burst_pkg;

    localparam int unsigned SYS_CLK_HZ   = 50_000_000;
    localparam int unsigned BURST_CLK_HZ = 25_000_000;
    localparam int unsigned BURST_DIV    = SYS_CLK_HZ / BURST_CLK_HZ;

    localparam logic [7:0] ADDR_RESULT_LOW  = 8'hBD;
    localparam logic [7:0] ADDR_RESULT_HIGH = 8'hBE;
    localparam logic [7:0] RESET_RESULT     = 8'h00;

    localparam logic [7:0] GAIN_ADDR_COARSE = 8'h04;
    localparam logic [7:0] GAIN_ADDR_FINE   = 8'h07;
    localparam logic [7:0] GAIN_ADDR_EXTRA  = 8'h08;
    localparam logic [7:0] GAIN_COARSE_RST  = 8'h00;
    localparam logic [3:0] GAIN_FINE_RST    = 4'h0;
    localparam int unsigned GAIN_FINE_LSB   = 4;
    localparam int unsigned GAIN_ADD_BIT    = 0;

    localparam logic [7:0] TRACK_TICKS  = 8'h03;
    localparam logic [7:0] POWERUP_UNIT = 8'h08;

    localparam logic [1:0] RPT_1  = 2'h0;
    localparam logic [1:0] RPT_4  = 2'h1;
    localparam logic [1:0] RPT_8  = 2'h2;
    localparam logic [1:0] RPT_16 = 2'h3;

    typedef struct packed {
        logic [7:0] coarse;
        logic [3:0] fine;
        logic       offset_add;
    } gain_t;

    typedef struct packed {
        logic        power_on;
        logic        track;
        logic        convert;
    } core_ctrl_t;

endpackage : adc_burst_pkg

// >>> testbench/adc_burst_gain_result_control_monitor.sv
// Assertion checker bound to the converter control block
`timescale 1ns/1ps
module adc_burst_gain_result_control_monitor
    import adc_burst_pkg::*;
(
    input wire logic       sys_clk,
    input wire logic       rst_b,
    input wire logic [7:0] sfr_addr,
    input wire logic       sfr_wr,
    input wire logic [7:0] sfr_rdata,
    input wire logic       burst_mode_on,
    input wire logic       converter_power_keep,
    input wire logic [1:0] repeat_count_field,
    input wire logic       left_justify_select,
    input wire logic       gain_access_enable,
    input wire logic       convert_start,
    input wire logic       done_clear,
    input wire logic       conversion_busy_bit,
    input wire logic       conversion_done_flag,
    input wire core_ctrl_t core_ctrl,
    input wire gain_t      gain_out
);
    // ====================
    // Short aliases
    wire busy = conversion_busy_bit;
    wire done = conversion_done_flag;
    wire pwr  = core_ctrl.power_on;
    wire trk  = core_ctrl.track;
    wire nog  = !gain_access_enable;
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_b);
    // ====================
    // Properties
    chk_start_busy:
    assert property (convert_start && !busy && (burst_mode_on || pwr) |=> busy)
        else $error("start did not raise busy");
    chk_done_fall:
    assert property ($fell(busy) && (burst_mode_on || repeat_count_field == RPT_1) |-> done)
        else $error("done missing at busy fall");
    chk_done_sticky:
    assert property (done && !done_clear |=> done) else $error("done dropped by itself");
    chk_done_clear:
    assert property (done_clear && !busy |=> !done) else $error("done not cleared");
    chk_track_power:
    assert property (trk |-> pwr) else $error("tracking while powered down");
    chk_powerup_wait:
    assert property (burst_mode_on && convert_start && !busy && !pwr |=> !trk [*8])
        else $error("no powerup wait");
    chk_idle_power:
    assert property ((!busy && $stable(converter_power_keep)) [*4] |-> pwr == converter_power_keep)
        else $error("idle power state wrong");
    chk_gain_hold:
    assert property (!(sfr_wr && gain_access_enable) |=> $stable(gain_out))
        else $error("gain changed without access");
    chk_gain_noread:
    assert property (!nog && sfr_addr == ADDR_RESULT_LOW |-> sfr_rdata == 8'h00)
        else $error("gain value readable");
    chk_rj_high:
    assert property (nog && !left_justify_select && sfr_addr == ADDR_RESULT_HIGH
        && repeat_count_field == RPT_1 |-> sfr_rdata[7:4] == 4'h0) else $error("high nibble set");
    chk_lj_low:
    assert property (nog && left_justify_select && sfr_addr == ADDR_RESULT_LOW
        |-> sfr_rdata[3:0] == 4'h0) else $error("low nibble set");
endmodule : adc_burst_gain_result_control_monitor

bind adc_burst_gain_result_control adc_burst_gain_result_control_monitor monitor_i (.*);

// >>> testbench/adc_burst_gain_result_control_test.sv
// Self-checking bench for the converter control block
`timescale 1ns/1ps
module adc_burst_gain_result_control_test;
    import adc_burst_pkg::*;
    logic        sys_clk, rst_b, sfr_wr, burst_mode_on, converter_power_keep;
    logic        left_justify_select, gain_access_enable, convert_start, done_clear;
    logic        conversion_busy_bit, conversion_done_flag, core_done;
    logic [7:0]  sfr_addr, sfr_wdata, sfr_rdata;
    logic [4:0]  powerup_delay_field;
    logic [1:0]  repeat_count_field;
    logic [11:0] core_data, code;
    logic [15:0] sum;
    core_ctrl_t  core_ctrl;
    gain_t       gain_out;
    int          errors, checks_done, cycles;
    int          nconv [4] = '{1, 4, 8, 16};
    logic [11:0] codes [4] = '{12'hABC, 12'h7A5, 12'h5C3, 12'hF7E};
    logic [7:0]  gptr [4]  = '{8'h05, GAIN_ADDR_COARSE, GAIN_ADDR_FINE, GAIN_ADDR_EXTRA};
    logic [7:0]  gval [4]  = '{8'hFF, 8'h6C, 8'hA0, 8'h01};

    adc_burst_gain_result_control DUT (.*);
    adc_core_model core_i (.*);

    initial
    begin
        sys_clk = 0;
        forever #10 sys_clk = ~sys_clk;
    end

    // ====================
    // Access tasks
    task check(input logic [15:0] seen, input logic [15:0] exp);
        checks_done++;
        if (seen !== exp)
        begin
            errors++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task sfr_write(input logic [7:0] a, input logic [7:0] d);
        @(negedge sys_clk) {sfr_addr, sfr_wdata, sfr_wr} = {a, d, 1'b1};
        @(negedge sys_clk) sfr_wr = 0;
    endtask : sfr_write

    task sfr_read(input logic [7:0] a, input logic [7:0] exp);
        @(negedge sys_clk) sfr_addr = a;
        #1 check(sfr_rdata, exp);
    endtask : sfr_read

    task start_conv;
        @(negedge sys_clk) convert_start = 1;
        @(negedge sys_clk) convert_start = 0;
        check(core_ctrl.track, converter_power_keep);
        for (int i = 0; i < 600 && conversion_busy_bit === 1'b1; i++) @(negedge sys_clk);
    endtask : start_conv

    task wrap_up;
        $display("checks %0d errors %0d", checks_done, errors);
        if (errors == 0 && checks_done > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : wrap_up

    always @(posedge sys_clk)
    begin
        cycles++;
        if (cycles == 10000)
        begin
            errors++;
            $display("[FAIL] %0t run timed out", $time);
            wrap_up;
        end
    end

    // ====================
    // Tests
    initial
    begin
        {rst_b, sfr_wr, burst_mode_on, left_justify_select, gain_access_enable} = 0;
        {convert_start, done_clear, sfr_addr, sfr_wdata, repeat_count_field, code} = 0;
        {errors, checks_done, cycles} = 0;
        converter_power_keep = 1;
        powerup_delay_field = 5'h02;
        repeat (16) @(posedge sys_clk);
        @(negedge sys_clk) rst_b = 1;
        sfr_read(ADDR_RESULT_LOW, RESET_RESULT);
        sfr_read(ADDR_RESULT_HIGH, RESET_RESULT);
        sfr_read(8'h80, 8'h00);
        check(gain_out, 16'h0000);
        $display("test reset done");
        gain_access_enable = 1;
        for (int g = 0; g < 4; g++)
        begin
            sfr_write(ADDR_RESULT_HIGH, gptr[g]);
            sfr_write(ADDR_RESULT_LOW, gval[g]);
        end
        sfr_read(ADDR_RESULT_HIGH, GAIN_ADDR_EXTRA);
        sfr_read(ADDR_RESULT_LOW, 8'h00);
        check(gain_out, {8'h6C, 4'hA, 1'b1});
        gain_access_enable = 0;
        sfr_write(ADDR_RESULT_LOW, 8'h55);
        check(gain_out, {8'h6C, 4'hA, 1'b1});
        $display("test gain done");
        for (int b = 0; b < 2; b++)
            for (int r = 0; r < 4; r++)
            begin
                burst_mode_on = b[0];
                converter_power_keep = ~(b[0] & r[0]);
                repeat_count_field = r[1:0];
                code = codes[r];
                for (int k = 0; k < (b ? 1 : nconv[r]); k++)
                begin
                    check(conversion_done_flag, 1'b0);
                    start_conv;
                end
                sum = 16'(nconv[r] * code);
                check(conversion_done_flag, 1'b1);
                sfr_read(ADDR_RESULT_HIGH, sum[15:8]);
                sfr_read(ADDR_RESULT_LOW, sum[7:0]);
                check(core_ctrl.power_on, converter_power_keep);
                @(negedge sys_clk) done_clear = 1;
                @(negedge sys_clk) done_clear = 0;
                check(conversion_done_flag, 1'b0);
                $display("test mode %0d repeat %0d done", b, r);
            end
        converter_power_keep = 1;
        {burst_mode_on, repeat_count_field, left_justify_select, code} = {1'b0, RPT_1, 1'b1, 12'h9D7};
        start_conv;
        check(conversion_done_flag, 1'b1);
        sfr_read(ADDR_RESULT_HIGH, 8'h9D);
        sfr_read(ADDR_RESULT_LOW, 8'h70);
        $display("test left justify done");
        wrap_up;
    end
endmodule : adc_burst_gain_result_control_test

// >>> testbench/adc_core_model.sv
// Behavioural converter core answering convert pulses
`timescale 1ns/1ps
module adc_core_model
    import adc_burst_pkg::*;
(
    input  wire logic        sys_clk,
    input  wire logic        rst_b,
    input  wire core_ctrl_t  core_ctrl,
    input  wire logic [11:0] code,
    output logic             core_done,
    output logic [11:0]      core_data
);
    logic [2:0] wait_q;
    logic       slow_q;
    // Alternates fast and slow answers; data toggles outside the valid cycle
    always_ff @(posedge sys_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            wait_q <= 3'h0;
            slow_q <= 1'b0;
            core_done <= 1'b0;
            core_data <= 12'h000;
        end
        else
        begin
            core_done <= (wait_q == 3'h1);
            core_data <= (wait_q == 3'h1) ? code : ~core_data;
            if (core_ctrl.convert && core_ctrl.power_on)
            begin
                wait_q <= slow_q ? 3'h6 : 3'h1;
                slow_q <= ~slow_q;
            end
            else if (wait_q != 3'h0)
                wait_q <= wait_q - 3'h1;
        end
    end
endmodule : adc_core_model
